// file: core/bpm_defs.vh
// offsets, field positions, reset values and timing counts of the battery protection monitor
`ifndef BPM_DEFS_VH
`define BPM_DEFS_VH
// register byte offsets
`define BPM_REG_PROT 8'h00
`define BPM_REG_STAT 8'h01
`define BPM_REG_CUR_HI 8'h0e
`define BPM_REG_CUR_LO 8'h0f
`define BPM_REG_ACC_HI 8'h10
`define BPM_REG_ACC_LO 8'h11
// protection register fields
`define BPM_PROT_HIGH 7
`define BPM_PROT_LOW 6
`define BPM_PROT_CHG_OC 5
`define BPM_PROT_DIS_OC 4
`define BPM_PROT_CC_PIN 3
`define BPM_PROT_DC_PIN 2
`define BPM_PROT_CPERMIT 1
`define BPM_PROT_DPERMIT 0
// status register fields
`define BPM_STAT_DSLEEP_EN 5
`define BPM_STAT_PSEL_EN 3
`define BPM_STAT_SLEEPING 0
// reset values
`define BPM_STAT_RST 8'h00
`define BPM_PERMIT_RST 1'b1
// timing: clock rate and the disconnect time in its own unit
`define BPM_CLK_HZ 50000000
`define BPM_DISC_SEC 2
`define BPM_DISC_CYC (`BPM_CLK_HZ * `BPM_DISC_SEC)
// protection qualification counts in clock cycles
`define BPM_HIGH_DLY 1000
`define BPM_LOW_DLY 1000
`define BPM_OC_DLY 500
`define BPM_SHORT_DLY 10
// accumulator fraction bits below the visible 16-bit word
`define BPM_ACC_FRAC 12
// current limits of the 12-bit signed register
`define BPM_CUR_MAX 16'sh07ff
`define BPM_CUR_MIN -16'sh0800
`endif

// file: core/bpm_top.v
// battery protection monitor: power modes, cell protection, current and accumulator
//
// Notes on behaviour
// - two power modes; measuring, accumulating and protecting happen only when active.
// - disconnect sleep enabled and data line low over two seconds enters sleep.
// - cell below low threshold past its delay: both fets off, flag, sleep.
// - pack select command with select enabled: disable sleeps, enable wakes.
// - asleep, data line rising wakes when disconnect sleep on, select off.
// - asleep, power switch pulled low wakes the device.
// - asleep, pack terminal above cell wakes when pack select is off.
// - device comes up active after reset.
// - protection monitoring of voltage and current only while active.
// - cell above high threshold past delay: charge fet off, flag set.
// - after overvoltage, charge returns once cell drops below resume threshold.
// - filtered sense above excess threshold past delay: both off, charge flag.
// - charge overcurrent sinks probe current; released when pack below margin.
// - sense below negative threshold past delay: discharge off, flag, probe source.
// - short on unfiltered sense past delay: discharge off, discharge flag.
// - discharge off on undervoltage, overcurrent, short, permit low or sleep.
// - charge off on overvoltage, undervoltage, charge overcurrent, permit low or sleep.
// - current stored as signed 12-bit value, saturating at the limits.
// - internal resistor mode scales by compensation gain into 0.625 mA steps.
// - external resistor mode stores sense voltage directly in 15.625 uV steps.
// - signed accumulator rises on charge, falls on discharge.
// - host may overwrite the accumulator anytime; a measurement in the same cycle as the write is not accumulated.
// - protection flags stay set until the host clears them.
// - recalling the second nonvolatile block sets both permit bits to one.
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`include "bpm_defs.vh"

// one delay qualifier: fires once the input has held past the delay
module bpm_qualify #(
  parameter DELAY = 1000
) (
  input wire clock,
  input wire sys_rst,
  input wire run,
  input wire cond,
  output wire trip
);
  reg [31:0] count;

  // restart whenever the comparator drops or monitoring stops
  always @(posedge clock) begin
    if (sys_rst || !run || !cond) begin
      count <= 32'h0000_0000;
    end else if (count != DELAY) begin
      count <= count + 32'h0000_0001;
    end
  end

  assign trip = run && cond && (count == DELAY);
endmodule // bpm_qualify

module bpm_top #(
  parameter DISC_CYCLES = `BPM_DISC_CYC,
  parameter HIGH_DELAY = `BPM_HIGH_DLY,
  parameter LOW_DELAY = `BPM_LOW_DLY,
  parameter OC_DELAY = `BPM_OC_DLY,
  parameter SHORT_DELAY = `BPM_SHORT_DLY
) (
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // host side pins and commands
  input wire host_data_line,
  input wire power_switch_input_n,
  input wire pack_select_command,
  input wire pack_select_enable_pack,
  input wire recall_block1,
  // comparator results, already in this clock domain
  input wire cell_above_high,
  input wire cell_below_low,
  input wire cell_below_resume,
  input wire sense_above_excess,
  input wire sense_below_neg_excess,
  input wire short_above_threshold,
  input wire pack_above_cell,
  input wire pack_below_release,
  input wire pack_above_release,
  // measurement stream
  input wire meas_valid,
  input wire signed [15:0] meas_value,
  input wire sense_internal,
  input wire [7:0] comp_gain,
  // outputs
  output wire charge_fet_drive,
  output wire discharge_fet_drive,
  output reg probe_sink,
  output reg probe_source,
  output wire active_mode
);
  localparam MODE_ACTIVE = 1'b0;
  localparam MODE_SLEEP = 1'b1;
  localparam [7:0] STAT_RST = `BPM_STAT_RST;

  reg mode;
  reg cell_high_flag, cell_low_flag;
  reg charge_excess_current_flag, discharge_excess_current_flag;
  reg charge_permit_bit, discharge_permit_bit;
  reg disconnect_sleep_enable, pack_select_enable;
  reg high_hold, low_hold, chg_oc_hold, dis_oc_hold;
  reg dq_s1, dq_s2, dq_s3, dq_lvl, dq_prev;
  reg ps_s1, ps_s2, ps_s3, ps_lvl;
  reg [31:0] disc_count;
  reg signed [11:0] current;
  reg signed [27:0] accum;
  wire run;
  wire high_trip, low_trip, chg_oc_trip, dis_oc_trip, short_trip;
  wire wr_prot, disc_expired;
  reg signed [24:0] scaled;
  reg signed [16:0] sat_in;
  reg signed [11:0] next_current;

  assign active_mode = (mode == MODE_ACTIVE);
  assign run = active_mode;
  assign wr_prot = reg_wr && (reg_addr == `BPM_REG_PROT);

  // three-stage pin synchronisers; a level counts when stages two and three agree
  always @(posedge clock) begin
    if (sys_rst) begin
      dq_s1 <= 1'b0;
      dq_s2 <= 1'b0;
      dq_s3 <= 1'b0;
      dq_lvl <= 1'b0;
      dq_prev <= 1'b0;
      ps_s1 <= 1'b1;
      ps_s2 <= 1'b1;
      ps_s3 <= 1'b1;
      ps_lvl <= 1'b1;
    end else begin
      dq_s1 <= host_data_line;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
      dq_prev <= dq_lvl;
      ps_s1 <= power_switch_input_n;
      ps_s2 <= ps_s1;
      ps_s3 <= ps_s2;
      if (dq_s2 == dq_s3) begin
        dq_lvl <= dq_s3;
      end
      if (ps_s2 == ps_s3) begin
        ps_lvl <= ps_s3;
      end
    end
  end

  // data line low timer for pack disconnection
  always @(posedge clock) begin
    if (sys_rst || dq_lvl || !active_mode) begin
      disc_count <= 32'h0000_0000;
    end else if (disc_count != DISC_CYCLES) begin
      disc_count <= disc_count + 32'h0000_0001;
    end
  end
  assign disc_expired = (disc_count == DISC_CYCLES); // longer than two seconds

  // delay qualifiers, one per protection condition
  bpm_qualify #(.DELAY(HIGH_DELAY)) u_high (
    .clock(clock), .sys_rst(sys_rst), .run(run),
    .cond(cell_above_high), .trip(high_trip)
  );
  bpm_qualify #(.DELAY(LOW_DELAY)) u_low (
    .clock(clock), .sys_rst(sys_rst), .run(run),
    .cond(cell_below_low), .trip(low_trip)
  );
  bpm_qualify #(.DELAY(OC_DELAY)) u_chg_oc (
    .clock(clock), .sys_rst(sys_rst), .run(run),
    .cond(sense_above_excess), .trip(chg_oc_trip)
  );
  bpm_qualify #(.DELAY(OC_DELAY)) u_dis_oc (
    .clock(clock), .sys_rst(sys_rst), .run(run),
    .cond(sense_below_neg_excess), .trip(dis_oc_trip)
  );
  bpm_qualify #(.DELAY(SHORT_DELAY)) u_short (
    .clock(clock), .sys_rst(sys_rst), .run(run),
    .cond(short_above_threshold), .trip(short_trip)
  );

  // power mode machine; a wake and a sleep never compete since each acts from one mode
  always @(posedge clock) begin
    if (sys_rst) begin
      mode <= MODE_ACTIVE;
    end else begin
      case (mode)
        MODE_ACTIVE: begin
          if (pack_select_command && pack_select_enable && !pack_select_enable_pack) begin
            mode <= MODE_SLEEP;
          end else if (disconnect_sleep_enable && disc_expired) begin
            mode <= MODE_SLEEP;
          end else if (low_trip) begin
            mode <= MODE_SLEEP;
          end
        end
        MODE_SLEEP: begin
          if (pack_select_command && pack_select_enable && pack_select_enable_pack) begin
            mode <= MODE_ACTIVE;
          end else if (disconnect_sleep_enable && !pack_select_enable &&
                       dq_lvl && !dq_prev) begin
            mode <= MODE_ACTIVE;
          end else if (!ps_lvl) begin
            mode <= MODE_ACTIVE;
          end else if (pack_above_cell && !pack_select_enable) begin
            mode <= MODE_ACTIVE;
          end
        end
        default: begin
          mode <= MODE_ACTIVE;
        end
      endcase
    end
  end

  // trip holds: each stays until its own release condition
  always @(posedge clock) begin
    if (sys_rst) begin
      high_hold <= 1'b0;
      low_hold <= 1'b0;
      chg_oc_hold <= 1'b0;
      dis_oc_hold <= 1'b0;
    end else begin
      if (high_trip) begin
        high_hold <= 1'b1;
      end else if (cell_below_resume) begin
        high_hold <= 1'b0;
      end
      if (low_trip) begin
        low_hold <= 1'b1;
      end else if (pack_above_cell) begin
        low_hold <= 1'b0; // charger attached
      end
      if (chg_oc_trip) begin
        chg_oc_hold <= 1'b1;
      end else if (pack_below_release) begin
        chg_oc_hold <= 1'b0;
      end
      if (dis_oc_trip || short_trip) begin
        dis_oc_hold <= 1'b1;
      end else if (pack_above_release) begin
        dis_oc_hold <= 1'b0;
      end
    end
  end

  // probe currents run only while an overcurrent waits for release
  always @(posedge clock) begin
    if (sys_rst) begin
      probe_sink <= 1'b0;
      probe_source <= 1'b0;
    end else begin
      probe_sink <= chg_oc_hold && !chg_oc_trip && !pack_below_release;
      probe_source <= dis_oc_hold && !pack_above_release;
    end
  end

  // fet drives, high means the fet conducts; a trip cuts it in the same cycle
  assign discharge_fet_drive = !(low_hold || low_trip || chg_oc_hold || chg_oc_trip ||
    dis_oc_hold || dis_oc_trip || short_trip ||
    !discharge_permit_bit || !active_mode);
  assign charge_fet_drive = !(high_hold || high_trip || low_hold || low_trip ||
    chg_oc_hold || chg_oc_trip || !charge_permit_bit || !active_mode);

  // protection register: sticky flags, set wins over a host clear
  always @(posedge clock) begin
    if (sys_rst) begin
      cell_high_flag <= 1'b0;
      cell_low_flag <= 1'b0;
      charge_excess_current_flag <= 1'b0;
      discharge_excess_current_flag <= 1'b0;
      charge_permit_bit <= `BPM_PERMIT_RST;
      discharge_permit_bit <= `BPM_PERMIT_RST;
    end else begin
      if (high_trip) begin
        cell_high_flag <= 1'b1;
      end else if (wr_prot && !reg_wdata[`BPM_PROT_HIGH]) begin
        cell_high_flag <= 1'b0;
      end
      if (low_trip) begin
        cell_low_flag <= 1'b1;
      end else if (wr_prot && !reg_wdata[`BPM_PROT_LOW]) begin
        cell_low_flag <= 1'b0;
      end
      if (chg_oc_trip) begin
        charge_excess_current_flag <= 1'b1;
      end else if (wr_prot && !reg_wdata[`BPM_PROT_CHG_OC]) begin
        charge_excess_current_flag <= 1'b0;
      end
      if (dis_oc_trip || short_trip) begin
        discharge_excess_current_flag <= 1'b1;
      end else if (wr_prot && !reg_wdata[`BPM_PROT_DIS_OC]) begin
        discharge_excess_current_flag <= 1'b0;
      end
      // recall outranks a same-cycle write to the permits
      if (recall_block1) begin
        charge_permit_bit <= 1'b1;
        discharge_permit_bit <= 1'b1;
      end else if (wr_prot) begin
        charge_permit_bit <= reg_wdata[`BPM_PROT_CPERMIT];
        discharge_permit_bit <= reg_wdata[`BPM_PROT_DPERMIT];
      end
    end
  end

  // status register control bits
  always @(posedge clock) begin
    if (sys_rst) begin
      disconnect_sleep_enable <= STAT_RST[`BPM_STAT_DSLEEP_EN];
      pack_select_enable <= STAT_RST[`BPM_STAT_PSEL_EN];
    end else if (reg_wr && (reg_addr == `BPM_REG_STAT)) begin
      disconnect_sleep_enable <= reg_wdata[`BPM_STAT_DSLEEP_EN];
      pack_select_enable <= reg_wdata[`BPM_STAT_PSEL_EN];
    end
  end

  // scale and saturate one measurement into the 12-bit register
  // sat_in keeps 17 bits so a full-scale gain product clamps instead of wrapping
  always @* begin
    scaled = meas_value * $signed({1'b0, comp_gain}); // gain is 1.7 fixed point
    if (sense_internal) begin
      sat_in = scaled[23:7];
    end else begin
      sat_in = {meas_value[15], meas_value};
    end
    if (sat_in > `BPM_CUR_MAX) begin
      next_current = 12'sh7ff;
    end else if (sat_in < `BPM_CUR_MIN) begin
      next_current = 12'sh800;
    end else begin
      next_current = sat_in[11:0];
    end
  end

  // current register and accumulator; host writes replace one byte and a same-cycle measurement is not accumulated
  always @(posedge clock) begin
    if (sys_rst) begin
      current <= 12'sh000;
      accum <= 28'sh0000000;
    end else begin
      if (meas_valid && active_mode) begin
        current <= next_current;
      end
      if (reg_wr && (reg_addr == `BPM_REG_ACC_HI)) begin
        accum <= {reg_wdata, accum[19:0]};
      end else if (reg_wr && (reg_addr == `BPM_REG_ACC_LO)) begin
        accum <= {accum[27:20], reg_wdata, accum[11:0]};
      end else if (meas_valid && active_mode) begin
        accum <= accum + {{16{next_current[11]}}, next_current};
      end
    end
  end

  // read data stands one cycle after the strobe, zero otherwise
  always @(posedge clock) begin
    if (sys_rst || !reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        `BPM_REG_PROT: reg_rdata <= {cell_high_flag, cell_low_flag,
          charge_excess_current_flag, discharge_excess_current_flag,
          !charge_fet_drive, !discharge_fet_drive,
          charge_permit_bit, discharge_permit_bit};
        `BPM_REG_STAT: reg_rdata <= {2'b00, disconnect_sleep_enable, 1'b0,
          pack_select_enable, 2'b00, !active_mode};
        `BPM_REG_CUR_HI: reg_rdata <= {{4{current[11]}}, current[11:8]};
        `BPM_REG_CUR_LO: reg_rdata <= current[7:0];
        `BPM_REG_ACC_HI: reg_rdata <= accum[27:20];
        `BPM_REG_ACC_LO: reg_rdata <= accum[19:12];
        default: reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule // bpm_top

// file: verification/bpm_checker.sv
// assertion checker for the battery protection monitor
`timescale 1ns/100ps
module bpm_checker #(
  parameter HIGH_DELAY = 1000,
  parameter LOW_DELAY = 1000,
  parameter OC_DELAY = 500,
  parameter SHORT_DELAY = 10
) (
  // clock and reset
  input logic clock,
  input logic sys_rst,
  // comparator and pin inputs
  input logic cell_above_high,
  input logic cell_below_low,
  input logic sense_above_excess,
  input logic sense_below_neg_excess,
  input logic short_above_threshold,
  input logic pack_below_release,
  input logic pack_above_release,
  input logic power_switch_input_n,
  // design outputs
  input logic charge_fet_drive,
  input logic discharge_fet_drive,
  input logic probe_sink,
  input logic probe_source,
  input logic active_mode
);
  int hi_n, lo_n, co_n, do_n, sc_n;
  default clocking @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // run lengths while active; counters avoid long repetitions
  always @(posedge clock) begin
    hi_n <= (sys_rst || !active_mode || !cell_above_high) ? 0 : hi_n + 1;
    lo_n <= (sys_rst || !active_mode || !cell_below_low) ? 0 : lo_n + 1;
    co_n <= (sys_rst || !active_mode || !sense_above_excess) ? 0 : co_n + 1;
    do_n <= (sys_rst || !active_mode || !sense_below_neg_excess) ? 0 : do_n + 1;
    sc_n <= (sys_rst || !active_mode || !short_above_threshold) ? 0 : sc_n + 1;
  end
  sleep_fets_off_a: assert property (
    !active_mode |-> !charge_fet_drive && !discharge_fet_drive) else $error("fet on in sleep");
  reset_active_a: assert property (
    $fell(sys_rst) |-> active_mode && charge_fet_drive && discharge_fet_drive)
    else $error("not active after reset");
  high_trip_a: assert property (
    hi_n >= HIGH_DELAY && cell_above_high && active_mode |-> !charge_fet_drive)
    else $error("charge on past high delay");
  low_sleep_a: assert property (
    lo_n >= LOW_DELAY && cell_below_low && active_mode
    |-> !charge_fet_drive && !discharge_fet_drive ##1 !active_mode) else $error("low trip");
  chg_oc_a: assert property (
    co_n >= OC_DELAY && sense_above_excess && active_mode
    |-> !charge_fet_drive && !discharge_fet_drive) else $error("charge overcurrent");
  dis_oc_a: assert property (
    do_n >= OC_DELAY && sense_below_neg_excess && active_mode |-> !discharge_fet_drive)
    else $error("discharge overcurrent");
  short_trip_a: assert property (
    sc_n >= SHORT_DELAY && short_above_threshold && active_mode |-> !discharge_fet_drive)
    else $error("short not tripped");
  sink_release_a: assert property (
    probe_sink && pack_below_release |=> !probe_sink) else $error("sink not released");
  source_release_a: assert property (
    probe_source && pack_above_release |=> !probe_source) else $error("source not released");
  switch_wake_a: assert property (
    !active_mode && !power_switch_input_n |-> ##[1:6] active_mode) else $error("no wake");
  // main scenarios reached
  cover property (lo_n >= LOW_DELAY && cell_below_low && active_mode);
  cover property ($rose(probe_source));
  cover property ($rose(probe_sink));
endmodule // bpm_checker

bind bpm_top bpm_checker #(.HIGH_DELAY(HIGH_DELAY), .LOW_DELAY(LOW_DELAY),
  .OC_DELAY(OC_DELAY), .SHORT_DELAY(SHORT_DELAY)) u_chk (.clock, .sys_rst,
  .cell_above_high, .cell_below_low, .sense_above_excess, .sense_below_neg_excess,
  .short_above_threshold, .pack_below_release, .pack_above_release, .power_switch_input_n,
  .charge_fet_drive, .discharge_fet_drive, .probe_sink, .probe_source, .active_mode);

// file: verification/bpm_host_model.sv
// host-side partner: data line, power switch and pack select command
`timescale 1ns/100ps
module bpm_host_model (
  // clock
  input logic clock,
  // toward the monitor
  output logic host_data_line,
  output logic power_switch_input_n,
  output logic pack_select_command,
  output logic pack_select_enable_pack
);
  logic attached = 1;
  logic closed = 0;
  // idle host holds the line high; detached, the pull-down wins
  assign host_data_line = attached;
  assign power_switch_input_n = !closed; // pull-up while open
  initial begin
    pack_select_command = 0;
    pack_select_enable_pack = 0;
  end
  task automatic plug(input logic on);
    @(posedge clock);
    attached <= on;
  endtask
  task automatic press(input int n);
    @(posedge clock);
    closed <= 1;
    repeat (n) @(posedge clock);
    closed <= 0;
  endtask
  // one-cycle command; the level flips after so a stale value cannot pass
  task automatic select(input logic en);
    @(posedge clock);
    pack_select_command <= 1;
    pack_select_enable_pack <= en;
    @(posedge clock);
    pack_select_command <= 0;
    pack_select_enable_pack <= !en;
  endtask
endmodule // bpm_host_model

// file: verification/bpm_top_tb_top.sv
// self-checking bench for the battery protection monitor
`timescale 1ns/100ps
module bpm_top_tb_top;
  localparam int HD = 3; // short qualifier delays keep the run brief
  logic clock = 0;
  logic sys_rst = 1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic recall_block1 = 0;
  logic meas_valid = 0;
  logic [15:0] meas_value = 16'h0000;
  logic sense_internal = 0;
  logic [7:0] comp_gain = 8'h80;
  logic [8:0] cmp = 9'h000; // comparator levels in port order
  wire [7:0] reg_rdata;
  wire cfd, dfd, probe_sink, probe_source, active_mode, dq, ps_n, sel, sel_en;
  int miscompares = 0;
  int checked = 0;
  logic [31:0] seed = 32'h7801;
  logic [27:0] acc = 28'h0000000;
  logic [11:0] cur = 12'h000;
  logic [15:0] corner [4] = '{16'h7fff, 16'h8000, 16'h07ff, 16'hf7ff};
  // 50 MHz clock
  initial begin
    forever #10 clock = ~clock;
  end
  bpm_top #(.DISC_CYCLES(20), .HIGH_DELAY(HD), .LOW_DELAY(HD), .OC_DELAY(HD),
    .SHORT_DELAY(HD)) dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .host_data_line(dq), .power_switch_input_n(ps_n), .pack_select_command(sel),
    .pack_select_enable_pack(sel_en), .recall_block1(recall_block1),
    .cell_above_high(cmp[0]), .cell_below_low(cmp[1]), .cell_below_resume(cmp[2]),
    .sense_above_excess(cmp[3]), .sense_below_neg_excess(cmp[4]),
    .short_above_threshold(cmp[5]), .pack_above_cell(cmp[6]), .pack_below_release(cmp[7]),
    .pack_above_release(cmp[8]), .meas_valid(meas_valid), .meas_value(meas_value),
    .sense_internal(sense_internal), .comp_gain(comp_gain), .charge_fet_drive(cfd),
    .discharge_fet_drive(dfd), .probe_sink(probe_sink), .probe_source(probe_source),
    .active_mode(active_mode));
  bpm_host_model host (.clock(clock), .host_data_line(dq), .power_switch_input_n(ps_n),
    .pack_select_command(sel), .pack_select_enable_pack(sel_en));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // expected current: gain in internal mode, then clamp to 12 bits
  function automatic logic [11:0] exp_cur(input logic [15:0] v, input logic i,
    input logic [7:0] g);
    logic signed [31:0] p;
    p = i ? (($signed(v) * $signed({24'h000000, g})) >>> 7) : 32'($signed(v));
    return (p > 2047) ? 12'h7ff : (p < -2048) ? 12'h800 : p[11:0];
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 0;
    #1;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 0;
    #1 chk($sformatf("reg %h", a), {8'h00, reg_rdata}, {8'h00, e});
  endtask
  task automatic pulse(input int i, input int n);
    @(posedge clock);
    cmp <= cmp | (9'h001 << i);
    repeat (n) @(posedge clock);
    cmp <= cmp & ~(9'h001 << i);
    #1;
  endtask
  // one measurement; asleep it must leave both values alone
  task automatic meas(input logic [15:0] v, input logic i, input logic [7:0] g, input bit live);
    @(posedge clock);
    meas_valid <= 1;
    meas_value <= v;
    sense_internal <= i;
    comp_gain <= g;
    @(posedge clock);
    meas_valid <= 0;
    meas_value <= ~v;
    if (live) cur = exp_cur(v, i, g);
    if (live) acc = acc + {{16{cur[11]}}, cur};
    rdc(8'h0e, {{4{cur[11]}}, cur[11:8]});
    rdc(8'h0f, cur[7:0]);
    rdc(8'h10, acc[27:20]);
    rdc(8'h11, acc[19:12]);
  endtask
  // hang guard, well beyond the expected run
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge clock);
    sys_rst <= 0;
    cyc(1);
    chk("reset", {active_mode, cfd, dfd, probe_sink, probe_source}, 5'b11100);
    rdc(8'h00, 8'h03);
    rdc(8'h01, 8'h00);
    // load accumulator while its fraction is still zero
    wr(8'h10, 8'h12);
    wr(8'h11, 8'h34);
    acc = 28'h1234000;
    for (int k = 0; k < 40; k++) begin
      repeat (8) seed = lfsr(seed);
      if (k < 4) meas(corner[k], 0, 8'h80, 1);
      else meas(seed[15:0], seed[16], seed[31:24], 1);
    end
    pulse(0, 8);
    chk("ov", {cfd, dfd}, 2'b01);
    pulse(2, 1);
    rdc(8'h00, 8'h83);
    chk("ov", {cfd, dfd}, 2'b11);
    wr(8'h00, 8'h00);
    chk("permit", {cfd, dfd}, 2'b00);
    @(posedge clock);
    recall_block1 <= 1;
    @(posedge clock);
    recall_block1 <= 0;
    cyc(1);
    chk("recall", {cfd, dfd}, 2'b11);
    pulse(3, 8);
    cyc(1); // the sink starts one cycle after the trip pulses stop
    chk("coc", {cfd, dfd, probe_sink}, 3'b001);
    rdc(8'h00, 8'h2f);
    pulse(7, 1);
    rdc(8'h00, 8'h23);
    chk("coc", {cfd, dfd, probe_sink}, 3'b110);
    wr(8'h00, 8'h03);
    for (int i = 4; i < 6; i++) begin
      pulse(i, 8);
      chk("doc", {cfd, dfd, probe_source}, 3'b101);
      rdc(8'h00, 8'h17);
      pulse(8, 1);
      rdc(8'h00, 8'h13);
      chk("doc", {cfd, dfd, probe_source}, 3'b110);
      wr(8'h00, 8'h03);
    end
    wr(8'h01, 8'h08);
    host.select(0);
    cyc(2);
    chk("mode", {active_mode, cfd, dfd}, 3'b000);
    rdc(8'h01, 8'h09);
    meas(16'h0123, 0, 8'h80, 0);
    pulse(0, 8);
    host.select(1);
    cyc(2);
    chk("mode", active_mode, 1'b1);
    rdc(8'h00, 8'h03);
    wr(8'h01, 8'h00);
    pulse(1, 8);
    chk("uv", {active_mode, cfd, dfd}, 3'b000);
    rdc(8'h00, 8'h4f);
    pulse(6, 1);
    cyc(2);
    wr(8'h00, 8'h03);
    chk("charger", {active_mode, cfd, dfd}, 3'b111);
    wr(8'h01, 8'h08);
    host.select(0);
    host.press(2);
    cyc(6);
    chk("switch", active_mode, 1'b1);
    host.plug(0);
    cyc(30);
    chk("disc", active_mode, 1'b1);
    wr(8'h01, 8'h20);
    cyc(30);
    chk("disc", active_mode, 1'b0);
    host.plug(1);
    cyc(8);
    chk("conn", active_mode, 1'b1);
    print_verdict();
  end
endmodule // bpm_top_tb_top
